// >>> err_mask_pkg.sv
/*
 * package for the error masking and alert block: widths, mask values, reset values.
 * assumes a single core clock and no register bus; bits arrive as plain ports.
 */
package err_mask_pkg;
    localparam int N_VOLT      = 16;
    localparam int N_TEMP      = 3;
    localparam int N_GPI       = 8;
    localparam int N_TACH      = 4;
    localparam int N_TERM      = 2;
    localparam int N_VRD       = 2;
    localparam int N_PROC      = 2;
    localparam int N_CLASS     = 6;
    localparam int N_ERR       = N_VOLT + N_TEMP + N_GPI + N_TACH + N_TERM + N_VRD + N_PROC;
    localparam int N_STATE     = 4;
    localparam logic [7:0] VOLT_MASK_LIMIT  = 8'hFF;
    localparam logic [7:0] TEMP_MASK_LIMIT  = 8'h80;
    localparam logic [7:0] TACH_MASK_LIMIT  = 8'hFF;
    localparam logic [7:0] USER_MASK_LIMIT  = 8'hFF;
    localparam logic [7:0] VOLT_LIMIT_RESET = 8'hFF;
    localparam logic [7:0] TEMP_LIMIT_RESET = 8'h80;
    localparam int CL_VOLT     = 0;
    localparam int CL_TEMP     = 1;
    localparam int CL_GPI      = 2;
    localparam int CL_TACH     = 3;
    localparam int CL_TERM     = 4;
    localparam int CL_VRD      = 5;
    localparam int OFS_VOLT    = 0;
    localparam int OFS_TEMP    = OFS_VOLT + N_VOLT;
    localparam int OFS_GPI     = OFS_TEMP + N_TEMP;
    localparam int OFS_TACH    = OFS_GPI + N_GPI;
    localparam int OFS_TERM    = OFS_TACH + N_TACH;
    localparam int OFS_VRD     = OFS_TERM + N_TERM;
    localparam int OFS_PROC    = OFS_VRD + N_VRD;
    // sleep states, one-hot
    typedef enum logic [N_STATE-1:0] {
        SLEEP_S0        = 4'h1,
        SLEEP_S1        = 4'h2,
        SLEEP_S3        = 4'h4,
        DEEP_SLEEP_STATE = 4'h8
    } sleep_state_t;
    // classes always masked in each sleep state
    localparam logic [N_CLASS-1:0] FORCE_S1   = 6'h08;
    localparam logic [N_CLASS-1:0] FORCE_S3   = 6'h0B;
    localparam logic [N_CLASS-1:0] FORCE_DEEP = 6'h1B;
    // classes masked by the sleep mask in each state
    localparam logic [N_CLASS-1:0] OPT_S1     = 6'h37;
    localparam logic [N_CLASS-1:0] OPT_S3     = 6'h34;
    localparam logic [N_CLASS-1:0] OPT_DEEP   = 6'h24;
endpackage

// >>> error_mask_alert_logic.sv
/*
 * error masking, duplicated management/host error status and alert output.
 * assumes monitored conditions and register write strobes are synchronous single-cycle inputs.
 */
`timescale 1ns/1ps
// Summary of operation
// - masked events never set either status bit
// - masking leaves an already set bit alone
// - voltage high limit FFh masks channel
// - temperature high limit 80h masks channel
// - masked temperature also hides diode faults
// - set input mask bit hides that pin
// - user throttle limit FFh masks status
// - fixed throttle status bits are never masked
// - fixed throttle bits never drive error outputs
// - tach limit FFh masks tach errors
// - termination and regulator bits masked individually
// - alert disabled until enable bit set
// - some classes always masked in sleep
// - some classes masked when sleep mask set
// - bits hold; write one clears if inactive
// - management and host clears are independent
// - standard mode makes management reads clear
// - external reset forces deepest sleep state
module error_mask_alert_logic
    import err_mask_pkg::*;
(
    // clock and resets
    input  wire logic                 ref_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 ext_rst_n_i,
    // monitored conditions
    input  wire logic [N_VOLT-1:0]    volt_err_i,
    input  wire logic [N_TEMP-1:0]    temp_err_i,
    input  wire logic [N_TEMP-1:0]    diode_fault_i,
    input  wire logic [N_GPI-1:0]     gpi_err_i,
    input  wire logic [N_TACH-1:0]    tach_err_i,
    input  wire logic [N_TERM-1:0]    bus_termination_input_i,
    input  wire logic [N_VRD-1:0]     regulator_hot_input_i,
    input  wire logic                 user_throttle_i,
    input  wire logic [N_PROC-1:0]    proc_throttle_status_i,
    // limits and masks
    input  wire logic [N_VOLT*8-1:0]  volt_high_limit_i,
    input  wire logic [N_TEMP*8-1:0]  temp_high_limit_i,
    input  wire logic [N_TACH*8-1:0]  tach_limit_i,
    input  wire logic [7:0]           user_throttle_limit_i,
    input  wire logic [N_GPI-1:0]     gpi_mask_i,
    input  wire logic [N_TERM-1:0]    term_mask_i,
    input  wire logic [N_VRD-1:0]     vrd_mask_i,
    input  wire logic [N_CLASS-1:0]   sleep_mask_i,
    // configuration
    input  wire logic                 alert_en_i,
    input  wire logic                 std_mode_i,
    input  wire logic                 sleep_wr_i,
    input  wire logic [N_STATE-1:0]   sleep_wdata_i,
    // status access
    input  wire logic [N_ERR-1:0]     mgmt_clr_i,
    input  wire logic [N_ERR-1:0]     host_clr_i,
    input  wire logic                 mgmt_rd_i,
    // status and outputs
    output logic      [N_ERR-1:0]     mgmt_status_o,
    output logic      [N_ERR-1:0]     host_status_o,
    output logic                      user_throttle_status_o,
    output logic      [N_STATE-1:0]   sleep_state_o,
    output logic                      mgmt_error_out_o,
    output logic                      host_error_out_o,
    output logic                      alert_o,
    output logic                      alert_oe_n_o
);

////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [N_ERR-1:0]   mgmt_reg;
        logic [N_ERR-1:0]   host_reg;
        logic               user_reg;
        sleep_state_t       sleep_reg;
        logic               alert_reg;
        logic               mgmt_out_reg;
        logic               host_out_reg;
    } state_t;

    state_t                 st_reg;
    state_t                 st_next;
    logic [N_ERR-1:0]       cond;
    logic [N_ERR-1:0]       unmask;
    logic [N_CLASS-1:0]     sleep_cl;
    logic [N_ERR-1:0]       alertable;

////////////////////////////////////////////////////////////////////////////////

    // sleep-state class masks
    always_comb
    begin
        case (st_reg.sleep_reg)
            SLEEP_S0:         sleep_cl = '0;
            SLEEP_S1:         sleep_cl = FORCE_S1 | (OPT_S1 & sleep_mask_i);
            SLEEP_S3:         sleep_cl = FORCE_S3 | (OPT_S3 & sleep_mask_i);
            DEEP_SLEEP_STATE: sleep_cl = FORCE_DEEP | (OPT_DEEP & sleep_mask_i);
            default:          sleep_cl = FORCE_DEEP;
        endcase
    end

    // per-bit unmask and raw conditions
    always_comb
    begin
        cond   = {proc_throttle_status_i, regulator_hot_input_i, bus_termination_input_i,
                  tach_err_i, gpi_err_i, temp_err_i | diode_fault_i, volt_err_i};
        unmask = '1;
        for (int i = 0; i < N_VOLT; i++)
            unmask[OFS_VOLT+i] = (volt_high_limit_i[i*8 +: 8] != VOLT_MASK_LIMIT) && !sleep_cl[CL_VOLT];
        for (int i = 0; i < N_TEMP; i++)
            unmask[OFS_TEMP+i] = (temp_high_limit_i[i*8 +: 8] != TEMP_MASK_LIMIT) && !sleep_cl[CL_TEMP];
        for (int i = 0; i < N_GPI; i++)
            unmask[OFS_GPI+i]  = !gpi_mask_i[i] && !sleep_cl[CL_GPI];
        for (int i = 0; i < N_TACH; i++)
            unmask[OFS_TACH+i] = (tach_limit_i[i*8 +: 8] != TACH_MASK_LIMIT) && !sleep_cl[CL_TACH];
        for (int i = 0; i < N_TERM; i++)
            unmask[OFS_TERM+i] = !term_mask_i[i] && !sleep_cl[CL_TERM];
        for (int i = 0; i < N_VRD; i++)
            unmask[OFS_VRD+i]  = !vrd_mask_i[i] && !sleep_cl[CL_VRD];
        // fixed throttle bits stay unmasked
        for (int i = 0; i < N_PROC; i++)
            unmask[OFS_PROC+i] = 1'b1;
    end

    // fixed throttle bits are informational only
    always_comb
    begin
        alertable = '1;
        alertable[OFS_PROC +: N_PROC] = '0;
    end

////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        st_next = st_reg;
        // set wins over clear; clear only when cause gone; masking never clears
        st_next.mgmt_reg = (st_reg.mgmt_reg & ~((mgmt_clr_i | {N_ERR{mgmt_rd_i & std_mode_i}}) & ~cond))
                           | (cond & unmask);
        st_next.host_reg = (st_reg.host_reg & ~(host_clr_i & ~cond))
                           | (cond & unmask);
        st_next.user_reg = st_reg.user_reg | (user_throttle_i && user_throttle_limit_i != USER_MASK_LIMIT);
        if (mgmt_clr_i[0] && !user_throttle_i)
            st_next.user_reg = 1'b0;
        if (!ext_rst_n_i)
            st_next.sleep_reg = DEEP_SLEEP_STATE;
        else if (sleep_wr_i)
        begin
            case (sleep_wdata_i)
                SLEEP_S0, SLEEP_S1, SLEEP_S3, DEEP_SLEEP_STATE:
                    st_next.sleep_reg = sleep_state_t'(sleep_wdata_i);
                default:
                    st_next.sleep_reg = st_reg.sleep_reg;
            endcase
        end
        st_next.mgmt_out_reg = |(st_next.mgmt_reg & alertable);
        st_next.host_out_reg = |(st_next.host_reg & alertable);
        st_next.alert_reg    = alert_en_i && |(st_next.host_reg & alertable);
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_reg <= '{mgmt_reg: '0, host_reg: '0, user_reg: 1'b0, sleep_reg: SLEEP_S0,
                        alert_reg: 1'b0, mgmt_out_reg: 1'b0, host_out_reg: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

////////////////////////////////////////////////////////////////////////////////

    assign mgmt_status_o          = st_reg.mgmt_reg;
    assign host_status_o          = st_reg.host_reg;
    assign user_throttle_status_o = st_reg.user_reg;
    assign sleep_state_o          = st_reg.sleep_reg;
    assign mgmt_error_out_o       = st_reg.mgmt_out_reg;
    assign host_error_out_o       = st_reg.host_out_reg;
    // open-drain alert: output low, enable low while pulling down
    assign alert_o                = 1'b0;
    assign alert_oe_n_o           = !st_reg.alert_reg;

////////////////////////////////////////////////////////////////////////////////

    masked_never_set_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (!st_reg.host_reg[OFS_VOLT+5] && !st_reg.mgmt_reg[OFS_VOLT+5]
         && volt_high_limit_i[5*8 +: 8] == VOLT_MASK_LIMIT)
        |=> (!st_reg.host_reg[OFS_VOLT+5] && !st_reg.mgmt_reg[OFS_VOLT+5])) else $error("masked voltage bit set");
    mask_keeps_bit_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (st_reg.host_reg[0] && !host_clr_i[0]) |=> st_reg.host_reg[0]) else $error("status bit lost");
    temp_mask_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (temp_high_limit_i[15:8] == TEMP_MASK_LIMIT && !st_reg.host_reg[OFS_TEMP+1]
         && !st_reg.mgmt_reg[OFS_TEMP+1])
        |=> (!st_reg.host_reg[OFS_TEMP+1] && !st_reg.mgmt_reg[OFS_TEMP+1]))
        else $error("masked temperature set");
    gpi_mask_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (gpi_err_i[0] && !gpi_mask_i[0] && st_reg.sleep_reg == SLEEP_S0) |=> st_reg.mgmt_reg[OFS_GPI])
        else $error("unmasked input not latched");
    proc_no_out_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (st_reg.host_reg[OFS_PROC-1:0] == '0) |-> !st_reg.alert_reg) else $error("throttle bit raised alert");
    alert_enable_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !alert_en_i |=> !st_reg.alert_reg) else $error("alert while disabled");
    clr_cond_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (st_reg.mgmt_reg[1] && mgmt_clr_i[1] && !cond[1]) |=> !st_reg.mgmt_reg[1]) else $error("clear ignored");
    side_indep_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (st_reg.host_reg[1] && mgmt_clr_i[1] && !host_clr_i[1]) |=> st_reg.host_reg[1])
        else $error("host bit cleared from management side");
    read_clear_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (std_mode_i && mgmt_rd_i && cond == '0) |=> st_reg.mgmt_reg == '0) else $error("read did not clear");
    ext_reset_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !ext_rst_n_i |=> st_reg.sleep_reg == DEEP_SLEEP_STATE) else $error("sleep not forced deep");
    dual_set_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (cond & unmask) != '0 |=> ((st_reg.mgmt_reg & st_reg.host_reg) != '0)) else $error("sides not set together");

endmodule

// >>> err_alert_partner.sv
/*
 * far-side model: management software writing the sleep state, plus the pulled-up alert wire.
 * assumes the same clock and power-on reset as the block.
 */
`timescale 1ns/1ps
module err_alert_partner
    import err_mask_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               arst_n_i,
    // bench request
    input  wire logic               req_i,
    input  wire logic [N_STATE-1:0] req_state_i,
    // block side
    input  wire logic               alert_oe_n_i,
    output logic                    sleep_wr_o,
    output logic [N_STATE-1:0]      sleep_wdata_o,
    output logic                    alert_wire_o
);
    // pull-up holds the wire high unless the block pulls it low
    assign alert_wire_o = alert_oe_n_i ? 1'b1 : 1'b0;
    // data outside the write pulse is scrambled so a stale value is never taken
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sleep_wr_o    <= 1'b0;
            sleep_wdata_o <= 4'h0;
        end
        else
        begin
            sleep_wr_o    <= req_i;
            sleep_wdata_o <= req_i ? req_state_i : ~sleep_wdata_o;
        end
    end
endmodule

// >>> error_mask_alert_logic_bench.sv
/*
 * self-checking bench for the error masking and alert block.
 * assumes the partner model for sleep writes and the alert pull-up.
 */
`timescale 1ns/1ps
module error_mask_alert_logic_bench;
    import err_mask_pkg::*;
    logic                clk, rst_n, ext_n, uthr, alert_en, std_mode, rd, req, swr, wire_a, ust, merr, herr, oe_n;
    logic [N_ERR-1:0]    cond, mclr, hclr, mst, hst;
    logic [N_TEMP-1:0]   diode;
    logic [N_VOLT*8-1:0] vlim;
    logic [N_TEMP*8-1:0] tlim;
    logic [N_TACH*8-1:0] flim;
    logic [7:0]          ulim, gmask;
    logic [1:0]          tmask, vmask;
    logic [N_CLASS-1:0]  smask;
    logic [N_STATE-1:0]  rstate, swd, sst;
    int                  fail_count, num_checks;
    ////////////////////////////////////////////////////////////////////////
    error_mask_alert_logic dut (.ref_clk_i(clk), .arst_n_i(rst_n), .ext_rst_n_i(ext_n),
        .volt_err_i(cond[OFS_VOLT+:N_VOLT]), .temp_err_i(cond[OFS_TEMP+:N_TEMP]), .diode_fault_i(diode),
        .gpi_err_i(cond[OFS_GPI+:N_GPI]), .tach_err_i(cond[OFS_TACH+:N_TACH]),
        .bus_termination_input_i(cond[OFS_TERM+:N_TERM]), .regulator_hot_input_i(cond[OFS_VRD+:N_VRD]),
        .user_throttle_i(uthr), .proc_throttle_status_i(cond[OFS_PROC+:N_PROC]), .volt_high_limit_i(vlim),
        .temp_high_limit_i(tlim), .tach_limit_i(flim), .user_throttle_limit_i(ulim), .gpi_mask_i(gmask),
        .term_mask_i(tmask), .vrd_mask_i(vmask), .sleep_mask_i(smask), .alert_en_i(alert_en),
        .std_mode_i(std_mode), .sleep_wr_i(swr), .sleep_wdata_i(swd), .mgmt_clr_i(mclr), .host_clr_i(hclr),
        .mgmt_rd_i(rd), .mgmt_status_o(mst), .host_status_o(hst), .user_throttle_status_o(ust),
        .sleep_state_o(sst), .mgmt_error_out_o(merr), .host_error_out_o(herr), .alert_o(), .alert_oe_n_o(oe_n));
    err_alert_partner partner (.ref_clk_i(clk), .arst_n_i(rst_n), .req_i(req), .req_state_i(rstate),
        .alert_oe_n_i(oe_n), .sleep_wr_o(swr), .sleep_wdata_o(swd), .alert_wire_o(wire_a));
    ////////////////////////////////////////////////////////////////////////
    task chk(string n, logic [127:0] s, logic [127:0] e);
        num_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [N_ERR-1:0] oh(int i);
        oh    = '0;
        oh[i] = 1'b1;
    endfunction
    // one-cycle condition pulse; status is settled on return
    task pulse(logic [N_ERR-1:0] v, logic [N_TEMP-1:0] d);
        @(posedge clk);
        cond  <= v;
        diode <= d;
        @(posedge clk);
        cond  <= '0;
        diode <= '0;
        #1;
    endtask
    task clr(logic [N_ERR-1:0] m, logic [N_ERR-1:0] h);
        @(posedge clk);
        mclr <= m;
        hclr <= h;
        @(posedge clk);
        mclr <= '0;
        hclr <= '0;
        #1;
    endtask
    task sleep_to(logic [N_STATE-1:0] st);
        @(posedge clk);
        req    <= 1'b1;
        rstate <= st;
        @(posedge clk);
        req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_basic;
        pulse(oh(3), 0);
        chk("mgmt_set", mst, oh(3));
        chk("host_set", hst, oh(3));
        chk("err_outs", {merr, herr, oe_n}, 3'b111);
        @(posedge clk);
        alert_en <= 1'b1;
        @(posedge clk);
        #1 chk("alert_wire", wire_a, 1'b0);
        clr('1, '1);
        chk("clr_idle", {mst, oe_n}, {37'h0, 1'b1});
        @(posedge clk);
        vlim[47:40] <= 8'hFF;
        pulse(oh(5), 0);
        chk("volt_mask", {mst, hst}, 74'h0);
    endtask
    task t_hold;
        @(posedge clk);
        cond[3] <= 1'b1;
        clr('0, oh(3));
        chk("set_wins", hst, oh(3));
        @(posedge clk);
        cond[3]     <= 1'b0;
        vlim[31:24] <= 8'hFF;
        clr('0, oh(3));
        chk("host_clr", hst, 37'h0);
        chk("mgmt_kept", mst, oh(3));
        clr('1, '1);
    endtask
    task t_class;
        @(posedge clk);
        tlim[15:8] <= 8'h80;
        gmask      <= 8'h04;
        flim[7:0]  <= 8'hFF;
        tmask      <= 2'h1;
        vmask      <= 2'h2;
        pulse(oh(OFS_TEMP+1) | oh(OFS_GPI+2) | oh(OFS_GPI+3) | oh(OFS_TACH) | oh(OFS_TERM) | oh(OFS_TERM+1)
              | oh(OFS_VRD+1), 3'h2);
        chk("class_mask", mst, oh(OFS_GPI+3) | oh(OFS_TERM+1));
        pulse(oh(OFS_PROC) | oh(OFS_PROC+1), 0);
        clr('1, ~(oh(OFS_PROC) | oh(OFS_PROC+1)));
        chk("proc_set", hst, oh(OFS_PROC) | oh(OFS_PROC+1));
        chk("proc_quiet", {merr, herr, oe_n}, 3'b001);
        clr('1, '1);
    endtask
    task t_user;
        @(posedge clk);
        uthr <= 1'b1;
        @(posedge clk);
        #1 chk("user_mask", ust, 1'b0);
        ulim <= 8'h00;
        @(posedge clk);
        uthr <= 1'b0;
        #1 chk("user_set", ust, 1'b1);
        clr('1, '1);
    endtask
    task t_sleep;
        smask <= 6'h04;
        tmask <= 2'h0;
        sleep_to(SLEEP_S3);
        chk("sleep_wr", sst, SLEEP_S3);
        pulse(oh(0) | oh(OFS_GPI) | oh(OFS_TERM), 0);
        chk("s3_mask", mst, oh(OFS_TERM));
        smask <= 6'h00;
        pulse(oh(OFS_GPI), 0);
        chk("s3_opt", mst, oh(OFS_GPI) | oh(OFS_TERM));
        @(posedge clk);
        ext_n <= 1'b0;
        @(posedge clk);
        ext_n <= 1'b1;
        #1 chk("ext_deep", sst, DEEP_SLEEP_STATE);
        pulse(oh(OFS_TERM+1), 0);
        chk("deep_mask", mst, oh(OFS_GPI) | oh(OFS_TERM));
        sleep_to(SLEEP_S0);
        clr('1, '1);
    endtask
    task t_std;
        std_mode <= 1'b1;
        pulse(oh(1), 0);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rd_clear", {mst, hst}, {37'h0, oh(1)});
        std_mode <= 1'b0;
        clr('1, '1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        {rst_n, uthr, alert_en, std_mode, rd, req, cond, mclr, hclr, diode, vlim, tlim, flim} = '0;
        {gmask, tmask, vmask, smask, rstate} = '0;
        ext_n = 1'b1;
        ulim  = 8'hFF;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk("rst_state", {sst, oe_n}, {SLEEP_S0, 1'b1});
        t_basic;
        t_hold;
        t_class;
        t_user;
        t_sleep;
        t_std;
        conclude;
    end
    // whole run is under a hundred cycles
    initial
    begin
        #20000;
        fail_count++;
        conclude;
    end
endmodule
